// file: src/qss_params.svh
// register selects, field positions, reset values and timing counts
// assumes inclusion by the sequencer, the queue memory and the bench
`ifndef QSS_PARAMS_SVH
`define QSS_PARAMS_SVH

// register selects on the native register port
`define QSS_SEL_MODE 3'h0
`define QSS_SEL_DELAY 3'h1
`define QSS_SEL_WRAP 3'h2
`define QSS_SEL_IRQ 3'h3
`define QSS_SEL_ADDR 3'h4
`define QSS_SEL_DATA 3'h5

// mode register fields
`define QSS_MODE_CLOCK_PHASE 8
`define QSS_MODE_CLOCK_POLARITY 9
`define QSS_MODE_BITS_LSB 10
`define QSS_MODE_RESET 16'h0000

// delay register fields
`define QSS_DLY_ENABLE 15
`define QSS_DLY_QCD_LSB 8
`define QSS_DLY_RESET 16'h0000

// wrap register fields
`define QSS_WRAP_EN 14
`define QSS_WRAP_IDLE 12
`define QSS_WRAP_END_LSB 8
`define QSS_WRAP_DONE_LSB 4
`define QSS_WRAP_START_LSB 0

// status register fields
`define QSS_IRQ_EN 8
`define QSS_IRQ_FLAG 0

// queue memory regions, upper two bits of the indirect address
`define QSS_RAM_TX 2'h0
`define QSS_RAM_RX 2'h1
`define QSS_RAM_CMD 2'h2

// word lengths
`define QSS_BITS_DEFAULT 5'h08
`define QSS_BITS_MAX 5'h10

// timing in bus clocks
`define QSS_HALF_CYC 14'h0002
`define QSS_STD_POST_CYC 14'h0011
`define QSS_POST_UNIT_LOG2 5
`define QSS_POST_ZERO_CYC 8192

`endif

// file: src/qss_pkg.sv
// types shared by the queued serial sequencer and its bench
// assumes the params header for all numeric constants
package qss_pkg;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_FETCH = 7'h02,
    ST_LOAD = 7'h04,
    ST_CSDLY = 7'h08,
    ST_SHIFT = 7'h10,
    ST_DONE = 7'h20,
    ST_POST = 7'h40
  } qss_state_t;

  typedef struct packed {
    logic holdSelectContinuous;
    logic wordLengthSelect;
    logic postTransferDelayEn;
    logic selectToClockDelayEn;
    logic [3:0] selectPattern;
  } qss_cmd_t;

  typedef struct packed {
    logic [2:0] sel;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } qss_req_t;

endpackage

// file: src/qss_queue_ram.sv
// queue memory: sixteen entries of command byte, transmit word, receive word
// assumes software writes only transmit and command, engine writes only receive
`timescale 1ns/10ps
`include "qss_params.svh"
module qss_queue_ram (
  input logic clk,
  input logic swWrEn,
  input logic swRdEn,
  input logic [5:0] swAddr,
  input logic [15:0] swWrData,
  output logic [15:0] swRdData,
  input logic [3:0] engIdx,
  output logic [15:0] engTxData,
  output logic [7:0] engCmd,
  input logic engWrEn,
  input logic [15:0] engWrData
);

  logic [15:0] txMem [16];
  logic [15:0] rxMem [16];
  logic [7:0] cmdMem [16];

  // contents are undefined after reset, so no reset on the arrays
  always_ff @(posedge clk) begin
    if (swWrEn && swAddr[5:4] == `QSS_RAM_TX) begin
      txMem[swAddr[3:0]] <= swWrData;
    end
    // command bytes only ever come from the upper byte of a software write
    if (swWrEn && swAddr[5:4] == `QSS_RAM_CMD) begin
      cmdMem[swAddr[3:0]] <= swWrData[15:8];
    end
    if (engWrEn) begin
      rxMem[engIdx] <= engWrData;
    end
    // transmit and command regions are write-only and read back as zero
    if (swRdEn) begin
      swRdData <= (swAddr[5:4] == `QSS_RAM_RX) ? rxMem[swAddr[3:0]] : 16'h0000;
    end
    engTxData <= txMem[engIdx];
    engCmd <= cmdMem[engIdx];
  end

endmodule

// file: src/qss_sequencer.sv
// queued serial master: register port, queue walker and serial shifter
// assumes one bus clock at 40 MHz and slaves on four active-low selects
// Operation
// - command entries change only by software writes to the data port upper byte
// - sixteen one-byte commands, each a select pattern plus transfer options
// - continuous bit clear: selects go idle after each word, else after queue
// - word length select clear gives eight bits, set uses the mode bit count
// - post-transfer delay enable picks the programmed delay over the standard one
// - select-to-clock delay: half serial period, or the programmed count if enabled
// - command bits 3-0 drive the four selects, zero asserts, several may be active
// - queue memory is sixteen entries of command byte, transmit and receive word
// - software loads queue then enables; device runs it and flags completion
// - hidden command pointer loads from the start pointer when execution begins
// - each step runs the command, copies pointer to done pointer, then increments
// - after each command compare end with done pointer; match sets flag, halts
// - wrap enable keeps the sequencer running past the end pointer
// - reset clears start and end pointers so execution starts at entry zero
// - start and end pointers accept writes at any time
// - new start pointer takes effect at once when idle, else after the transfer
// - start and end both zero gives exactly one transfer
// - all four clock phase and polarity combinations are supported
// - words shift out and in most significant bit first
// - word length defaults to eight and may be programmed from 8 to 16
// - flag sets at each end-pointer completion in wrap mode; write one clears
// - post delay is 32 clocks per count, zero gives 8192, standard is 17
// - select-to-clock delay equals its count in clocks, zero means half period
`timescale 1ns/10ps
`include "qss_params.svh"
module qss_sequencer #(
  parameter int POST_ZERO_CYC = `QSS_POST_ZERO_CYC
) (
  input logic clk,
  input logic resetn,
  input qss_pkg::qss_req_t regReq,
  output logic [15:0] regRdData,
  output logic regRdAck,
  output logic spiSck,
  output logic spiMosi,
  input logic spiMiso,
  output logic [3:0] spiCsN,
  output logic queueDoneIrq
);

  // register group
  logic [15:0] mode_reg, mode_next;
  logic [6:0] qcd_reg, qcd_next;
  logic [7:0] dtl_reg, dtl_next;
  logic enable_reg, enable_next;
  logic wrapEn_reg, wrapEn_next;
  logic idleLevel_reg, idleLevel_next;
  logic [3:0] startPtr_reg, startPtr_next;
  logic [3:0] endPtr_reg, endPtr_next;
  logic irqEn_reg, irqEn_next;
  logic doneFlag_reg, doneFlag_next;
  logic [5:0] addr_reg, addr_next;
  logic rdPend_reg, rdPend_next;
  logic rdFromRam_reg, rdFromRam_next;
  logic [15:0] rdHold_reg, rdHold_next;
  logic newPend_reg, newPend_next;

  // engine group
  qss_pkg::qss_state_t state_reg, state_next;
  qss_pkg::qss_cmd_t cmd_reg, cmd_next;
  logic [3:0] ptr_reg, ptr_next;
  logic [3:0] donePtr_reg, donePtr_next;
  logic [13:0] cnt_reg, cnt_next;
  logic [5:0] edgeCnt_reg, edgeCnt_next;
  logic [4:0] bits_reg, bits_next;
  logic [15:0] txShift_reg, txShift_next;
  logic [15:0] rxShift_reg, rxShift_next;
  logic sck_reg, sck_next;
  logic mosi_reg, mosi_next;
  logic [3:0] cs_reg, cs_next;
  // sampling one clock after the edge lets the two-flop miso path settle
  logic samplePend_reg, samplePend_next;

  logic misoMeta_reg, misoSync_reg;
  logic setFlag, clearEnable, takeNewStart, ramWrEn, edgeNow, sampleEdge;
  logic [15:0] ramTx, ramSwRd, txAligned, readMux;
  logic [7:0] ramCmd;
  qss_pkg::qss_cmd_t ramCmdS;
  logic [4:0] modeBits, wordBits;
  logic [3:0] idlePattern;
  logic [13:0] postLoad;
  logic clock_phase, clock_polarity, swDataWr, swDataRd;

  assign clock_phase = mode_reg[`QSS_MODE_CLOCK_PHASE];
  assign clock_polarity = mode_reg[`QSS_MODE_CLOCK_POLARITY];
  assign ramCmdS = ramCmd;
  // bit count field 8..15 is taken as is; 0 means sixteen, 1..7 fall back to sixteen
  assign modeBits = mode_reg[`QSS_MODE_BITS_LSB + 3] ?
    {1'b0, mode_reg[`QSS_MODE_BITS_LSB +: 4]} : `QSS_BITS_MAX;
  assign wordBits = ramCmdS.wordLengthSelect ? modeBits : `QSS_BITS_DEFAULT;
  // right-justified transmit data is moved up so the first bit out is always bit 15
  assign txAligned = ramTx << (`QSS_BITS_MAX - wordBits);
  assign idlePattern = idleLevel_reg ? 4'hf : 4'h0;
  assign postLoad = !cmd_reg.postTransferDelayEn ? `QSS_STD_POST_CYC - 14'h0001 :
    (dtl_reg == 8'h00) ? 14'(POST_ZERO_CYC - 1) :
    {1'b0, dtl_reg, 5'h00} - 14'h0001;
  assign swDataWr = regReq.wr && regReq.sel == `QSS_SEL_DATA;
  assign swDataRd = regReq.rd && regReq.sel == `QSS_SEL_DATA;

  qss_queue_ram u_ram (
    .clk(clk),
    .swWrEn(swDataWr),
    .swRdEn(swDataRd),
    .swAddr(addr_reg),
    .swWrData(regReq.wdata),
    .swRdData(ramSwRd),
    .engIdx(ptr_reg),
    .engTxData(ramTx),
    .engCmd(ramCmd),
    .engWrEn(ramWrEn),
    .engWrData(rxShift_reg)
  );

  always_comb begin
    unique case (regReq.sel)
      `QSS_SEL_MODE: readMux = mode_reg;
      `QSS_SEL_DELAY: readMux = {enable_reg, qcd_reg, dtl_reg};
      `QSS_SEL_WRAP: readMux = {1'b0, wrapEn_reg, 1'b0, idleLevel_reg, endPtr_reg,
        donePtr_reg, startPtr_reg};
      `QSS_SEL_IRQ: readMux = {7'h00, irqEn_reg, 7'h00, doneFlag_reg};
      `QSS_SEL_ADDR: readMux = {10'h000, addr_reg};
      default: readMux = 16'h0000;
    endcase
  end

  always_comb begin
    mode_next = mode_reg;
    qcd_next = qcd_reg;
    dtl_next = dtl_reg;
    enable_next = enable_reg;
    wrapEn_next = wrapEn_reg;
    idleLevel_next = idleLevel_reg;
    startPtr_next = startPtr_reg;
    endPtr_next = endPtr_reg;
    irqEn_next = irqEn_reg;
    doneFlag_next = doneFlag_reg;
    addr_next = addr_reg;
    rdPend_next = regReq.rd;
    rdFromRam_next = swDataRd;
    rdHold_next = regReq.rd ? readMux : rdHold_reg;
    newPend_next = takeNewStart ? 1'b0 : newPend_reg;
    if (clearEnable) begin
      enable_next = 1'b0;
    end
    if (regReq.wr) begin
      unique case (regReq.sel)
        `QSS_SEL_MODE: mode_next = regReq.wdata;
        `QSS_SEL_DELAY: begin
          enable_next = regReq.wdata[`QSS_DLY_ENABLE];
          qcd_next = regReq.wdata[`QSS_DLY_QCD_LSB +: 7];
          dtl_next = regReq.wdata[7:0];
        end
        `QSS_SEL_WRAP: begin
          wrapEn_next = regReq.wdata[`QSS_WRAP_EN];
          idleLevel_next = regReq.wdata[`QSS_WRAP_IDLE];
          endPtr_next = regReq.wdata[`QSS_WRAP_END_LSB +: 4];
          startPtr_next = regReq.wdata[`QSS_WRAP_START_LSB +: 4];
          // a busy walker finishes its word before honouring the new start
          if (state_reg != qss_pkg::ST_IDLE &&
              startPtr_next != startPtr_reg) begin
            newPend_next = 1'b1;
          end
        end
        `QSS_SEL_IRQ: begin
          irqEn_next = regReq.wdata[`QSS_IRQ_EN];
          if (regReq.wdata[`QSS_IRQ_FLAG]) begin
            doneFlag_next = 1'b0;
          end
        end
        `QSS_SEL_ADDR: addr_next = regReq.wdata[5:0];
        `QSS_SEL_DATA: addr_next = addr_reg + 6'h01;
        default: ;
      endcase
    end
    // the address does not wrap per region; software keeps it in range
    if (swDataRd) begin
      addr_next = addr_reg + 6'h01;
    end
    // set after the write-one clear so a same-cycle completion is kept
    if (setFlag) begin
      doneFlag_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= `QSS_MODE_RESET;
      qcd_reg <= 7'h00;
      dtl_reg <= 8'h00;
      enable_reg <= 1'b0;
      wrapEn_reg <= 1'b0;
      idleLevel_reg <= 1'b1;
      startPtr_reg <= 4'h0;
      endPtr_reg <= 4'h0;
      irqEn_reg <= 1'b0;
      doneFlag_reg <= 1'b0;
      addr_reg <= 6'h00;
      rdPend_reg <= 1'b0;
      rdFromRam_reg <= 1'b0;
      rdHold_reg <= 16'h0000;
      newPend_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      qcd_reg <= qcd_next;
      dtl_reg <= dtl_next;
      enable_reg <= enable_next;
      wrapEn_reg <= wrapEn_next;
      idleLevel_reg <= idleLevel_next;
      startPtr_reg <= startPtr_next;
      endPtr_reg <= endPtr_next;
      irqEn_reg <= irqEn_next;
      doneFlag_reg <= doneFlag_next;
      addr_reg <= addr_next;
      rdPend_reg <= rdPend_next;
      rdFromRam_reg <= rdFromRam_next;
      rdHold_reg <= rdHold_next;
      newPend_reg <= newPend_next;
    end
  end

  assign regRdAck = rdPend_reg;
  assign regRdData = rdFromRam_reg ? ramSwRd : rdHold_reg;
  assign queueDoneIrq = doneFlag_reg & irqEn_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      misoMeta_reg <= 1'b0;
      misoSync_reg <= 1'b0;
    end else begin
      misoMeta_reg <= spiMiso;
      misoSync_reg <= misoMeta_reg;
    end
  end

  assign edgeNow = (state_reg == qss_pkg::ST_CSDLY || state_reg == qss_pkg::ST_SHIFT) &&
    cnt_reg == 14'h0000 && edgeCnt_reg != {bits_reg, 1'b0};
  // leading edges are even; phase zero samples on them, phase one on trailing
  assign sampleEdge = edgeCnt_reg[0] == clock_phase;

  always_comb begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    ptr_next = ptr_reg;
    donePtr_next = donePtr_reg;
    cnt_next = cnt_reg;
    edgeCnt_next = edgeCnt_reg;
    bits_next = bits_reg;
    txShift_next = txShift_reg;
    rxShift_next = rxShift_reg;
    sck_next = sck_reg;
    mosi_next = mosi_reg;
    cs_next = cs_reg;
    samplePend_next = 1'b0;
    setFlag = 1'b0;
    clearEnable = 1'b0;
    takeNewStart = 1'b0;
    ramWrEn = 1'b0;
    unique case (state_reg)
      qss_pkg::ST_IDLE: begin
        ptr_next = startPtr_reg;
        sck_next = clock_polarity;
        cs_next = idlePattern;
        if (enable_reg) begin
          state_next = qss_pkg::ST_FETCH;
        end
      end
      qss_pkg::ST_FETCH: state_next = qss_pkg::ST_LOAD;
      qss_pkg::ST_LOAD: begin
        cmd_next = ramCmdS;
        bits_next = wordBits;
        cs_next = ramCmdS.selectPattern;
        sck_next = clock_polarity;
        rxShift_next = 16'h0000;
        edgeCnt_next = 6'h00;
        if (!clock_phase) begin
          mosi_next = txAligned[15];
          txShift_next = {txAligned[14:0], 1'b0};
        end else begin
          txShift_next = txAligned;
        end
        cnt_next = (ramCmdS.selectToClockDelayEn && qcd_reg != 7'h00) ?
          {7'h00, qcd_reg} - 14'h0001 : `QSS_HALF_CYC - 14'h0001;
        state_next = qss_pkg::ST_CSDLY;
      end
      qss_pkg::ST_CSDLY: begin
        if (cnt_reg == 14'h0000) begin
          cnt_next = `QSS_HALF_CYC - 14'h0001;
          state_next = qss_pkg::ST_SHIFT;
        end else begin
          cnt_next = cnt_reg - 14'h0001;
        end
      end
      qss_pkg::ST_SHIFT: begin
        if (cnt_reg == 14'h0000) begin
          cnt_next = `QSS_HALF_CYC - 14'h0001;
          if (edgeCnt_reg == {bits_reg, 1'b0}) begin
            state_next = qss_pkg::ST_DONE;
          end
        end else begin
          cnt_next = cnt_reg - 14'h0001;
        end
      end
      qss_pkg::ST_DONE: begin
        ramWrEn = 1'b1;
        donePtr_next = ptr_reg;
        if (ptr_reg == endPtr_reg) begin
          setFlag = 1'b1;
        end
        if (!cmd_reg.holdSelectContinuous) begin
          cs_next = idlePattern;
        end
        cnt_next = postLoad;
        state_next = qss_pkg::ST_POST;
      end
      qss_pkg::ST_POST: begin
        if (cnt_reg != 14'h0000) begin
          cnt_next = cnt_reg - 14'h0001;
        end else if ((donePtr_reg == endPtr_reg && !wrapEn_reg) || !enable_reg) begin
          // a single entry with both pointers at zero also ends here
          clearEnable = 1'b1;
          cs_next = idlePattern;
          state_next = qss_pkg::ST_IDLE;
        end else begin
          state_next = qss_pkg::ST_FETCH;
          if (donePtr_reg == endPtr_reg || newPend_reg) begin
            takeNewStart = 1'b1;
            ptr_next = startPtr_reg;
          end else begin
            ptr_next = ptr_reg + 4'h1;
          end
        end
      end
    endcase
    if (edgeNow) begin
      sck_next = ~sck_reg;
      edgeCnt_next = edgeCnt_reg + 6'h01;
      samplePend_next = sampleEdge;
      if (!sampleEdge) begin
        mosi_next = txShift_reg[15];
        txShift_next = {txShift_reg[14:0], 1'b0};
      end
    end
    // the slave changes miso only two clocks before the sampling edge, but the
    // synchroniser needs three, so the bit is taken one clock after that edge
    if (samplePend_reg) begin
      rxShift_next = {rxShift_reg[14:0], misoSync_reg};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= qss_pkg::ST_IDLE;
      cmd_reg <= '0;
      ptr_reg <= 4'h0;
      donePtr_reg <= 4'h0;
      cnt_reg <= 14'h0000;
      edgeCnt_reg <= 6'h00;
      bits_reg <= `QSS_BITS_DEFAULT;
      txShift_reg <= 16'h0000;
      rxShift_reg <= 16'h0000;
      sck_reg <= 1'b0;
      mosi_reg <= 1'b0;
      cs_reg <= 4'hf;
      samplePend_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      ptr_reg <= ptr_next;
      donePtr_reg <= donePtr_next;
      cnt_reg <= cnt_next;
      edgeCnt_reg <= edgeCnt_next;
      bits_reg <= bits_next;
      txShift_reg <= txShift_next;
      rxShift_reg <= rxShift_next;
      sck_reg <= sck_next;
      mosi_reg <= mosi_next;
      cs_reg <= cs_next;
      samplePend_reg <= samplePend_next;
    end
  end

  assign spiSck = sck_reg;
  assign spiMosi = mosi_reg;
  assign spiCsN = cs_reg;

  a_reset_ptrs: assert property (
    @(posedge clk) $rose(resetn) |-> startPtr_reg == 4'h0 && endPtr_reg == 4'h0)
    else $error("pointers not cleared by reset");
  a_cs_pattern: assert property (
    @(posedge clk) disable iff (!resetn)
    state_reg == qss_pkg::ST_LOAD |=> spiCsN == $past(ramCmd[3:0]))
    else $error("select pins do not follow command bits");
  a_cs_idle: assert property (
    @(posedge clk) disable iff (!resetn)
    state_reg == qss_pkg::ST_DONE && !cmd_reg.holdSelectContinuous
    |=> spiCsN == idlePattern)
    else $error("selects not idle after a non-continuous word");
  a_done_copy: assert property (
    @(posedge clk) disable iff (!resetn)
    state_reg == qss_pkg::ST_DONE |=> donePtr_reg == $past(ptr_reg) && ptr_reg == $past(ptr_reg))
    else $error("done pointer not copied before increment");
  a_flag_end: assert property (
    @(posedge clk) disable iff (!resetn)
    state_reg == qss_pkg::ST_DONE && ptr_reg == endPtr_reg |=> doneFlag_reg)
    else $error("end command did not set the done flag");
  a_wrap_reload: assert property (
    @(posedge clk) disable iff (!resetn)
    state_reg == qss_pkg::ST_POST && cnt_reg == 14'h0000 && enable_reg && wrapEn_reg &&
    donePtr_reg == endPtr_reg |=> state_reg == qss_pkg::ST_FETCH && ptr_reg == $past(startPtr_reg))
    else $error("wrap did not reload the start pointer");
  a_idle_follow: assert property (
    @(posedge clk) disable iff (!resetn)
    state_reg == qss_pkg::ST_IDLE && $past(state_reg) == qss_pkg::ST_IDLE
    |-> ptr_reg == $past(startPtr_reg))
    else $error("idle pointer does not follow the start pointer");
  a_std_post: assert property (
    @(posedge clk) disable iff (!resetn)
    state_reg == qss_pkg::ST_DONE && !cmd_reg.postTransferDelayEn
    |=> state_reg == qss_pkg::ST_POST ##16 state_reg == qss_pkg::ST_POST
    ##1 state_reg != qss_pkg::ST_POST)
    else $error("standard post delay is not 17 clocks");
  a_half_delay: assert property (
    @(posedge clk) disable iff (!resetn)
    state_reg == qss_pkg::ST_LOAD && !ramCmdS.selectToClockDelayEn
    |=> $stable(spiSck) ##1 $stable(spiSck) ##1 spiSck != $past(spiSck))
    else $error("select to clock is not half a serial period");
  a_msb_first: assert property (
    @(posedge clk) disable iff (!resetn)
    state_reg == qss_pkg::ST_LOAD && !clock_phase |=> spiMosi == $past(txAligned[15]))
    else $error("first bit out is not the word msb");

endmodule

// file: dv/qss_spi_slave.sv
// serial slave model: samples mosi, answers a reply word on miso
// assumes the bench gives mode and word length before each select
`timescale 1ns/10ps
module qss_spi_slave (
  input wire logic sck,
  input wire logic mosi,
  input wire logic csN,
  input wire logic clock_polarity,
  input wire logic clock_phase,
  input wire logic [4:0] nBits,
  input wire logic [15:0] reply,
  output logic miso,
  output logic [15:0] gotWord,
  output logic [4:0] gotBits
);
  int idx;
  logic [15:0] shiftIn;
  initial begin
    miso = 1'b0;
    gotWord = 16'h0000;
    gotBits = 5'h00;
    shiftIn = 16'h0000;
  end
  always @(negedge csN) begin
    shiftIn = 16'h0000;
    gotBits = 5'h00;
    idx = nBits - 1;
    if (!clock_phase) begin
      miso = reply[idx];
      idx--;
    end
  end
  // released line shows the inverse so a stale bit cannot pass
  always @(posedge csN) begin
    gotWord = shiftIn;
    miso = ~miso;
  end
  always @(sck) begin
    if (!csN && sck == (clock_polarity ~^ clock_phase)) begin
      shiftIn = {shiftIn[14:0], mosi};
      gotBits++;
    end else if (!csN) begin
      miso = (idx >= 0) ? reply[idx] : ~miso;
      idx--;
    end
  end
endmodule

// file: dv/qss_sequencer_tb.sv
// bench for the queued serial sequencer: row table, then queue runs
// assumes one slave model on select 0 and the native register port
`timescale 1ns/10ps
`include "qss_params.svh"
module qss_sequencer_tb;
  typedef struct {
    logic [15:0] mode;
    logic [7:0] cmd;
    logic [15:0] tx;
    logic [15:0] rep;
    int n;
  } qss_row_t;
  qss_row_t rows [5] = '{
    '{16'h0000, 8'h0E, 16'h00A5, 16'h003C, 8},
    '{16'h0100, 8'h0C, 16'h005A, 16'h00C3, 8},
    '{16'h0200, 8'h4A, 16'hBEEF, 16'h1234, 16},
    '{16'h3300, 8'h46, 16'hFABC, 16'h0F0F, 12},
    '{16'h3000, 8'h06, 16'h0181, 16'h0055, 8}};
  logic clk;
  logic resetn;
  qss_pkg::qss_req_t regReq;
  logic [15:0] regRdData;
  logic regRdAck;
  logic spiSck;
  logic spiMosi;
  logic spiMiso;
  logic [3:0] spiCsN;
  logic queueDoneIrq;
  logic clock_polarity;
  logic clock_phase;
  logic [4:0] nBits;
  logic [15:0] reply;
  logic [15:0] gotWord;
  logic [4:0] gotBits;
  logic [15:0] rd;
  logic [15:0] mask;
  logic [3:0] prevCs;
  logic [3:0] seenCs;
  logic prevSck;
  logic sckSeen;
  int bad_count;
  int check_count;
  int cyc;
  int fallAt;
  int riseAt;
  int gap;
  int leadDly;
  int csRises;
  int r0;
  qss_sequencer #(.POST_ZERO_CYC(100)) i_qss_sequencer (.clk(clk), .resetn(resetn),
    .regReq(regReq), .regRdData(regRdData), .regRdAck(regRdAck), .spiSck(spiSck),
    .spiMosi(spiMosi), .spiMiso(spiMiso), .spiCsN(spiCsN), .queueDoneIrq(queueDoneIrq));
  qss_spi_slave i_qss_spi_slave (.sck(spiSck), .mosi(spiMosi), .csN(spiCsN[0]),
    .clock_polarity(clock_polarity), .clock_phase(clock_phase), .nBits(nBits), .reply(reply), .miso(spiMiso),
    .gotWord(gotWord), .gotBits(gotBits));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // edge timing of select 0 and the serial clock, in bus clocks
  always @(posedge clk) begin
    cyc <= cyc + 1;
    prevCs <= spiCsN;
    prevSck <= spiSck;
    if (prevCs[0] && !spiCsN[0]) begin
      fallAt <= cyc;
      sckSeen <= 1'b0;
      gap <= cyc - riseAt;
    end
    if (!prevCs[0] && spiCsN[0]) begin
      riseAt <= cyc;
      csRises <= csRises + 1;
    end
    if (!spiCsN[0] && spiSck !== prevSck && !sckSeen) begin
      sckSeen <= 1'b1;
      leadDly <= cyc - fallAt;
    end
    if (spiCsN !== 4'hF) seenCs <= spiCsN;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic regOp(input logic [2:0] sel, input logic wr, input logic [15:0] data);
    @(posedge clk);
    #2;
    regReq = '{sel, wr, !wr, data};
    @(posedge clk);
    #2;
    regReq.wr = 1'b0;
    regReq.rd = 1'b0;
    rd = regRdData;
    if (!wr && regRdAck !== 1'b1) check("read ack", 16'h0001, 16'h0000);
  endtask
  task automatic load(input logic [3:0] idx, input logic [7:0] cmd, input logic [15:0] tx);
    regOp(`QSS_SEL_ADDR, 1'b1, {12'h000, idx});
    regOp(`QSS_SEL_DATA, 1'b1, tx);
    regOp(`QSS_SEL_ADDR, 1'b1, {12'h002, idx});
    regOp(`QSS_SEL_DATA, 1'b1, {cmd, 8'h00});
  endtask
  task automatic waitDone;
    for (int k = 0; k < 3000; k++) begin
      regOp(`QSS_SEL_IRQ, 1'b0, 16'h0000);
      if (rd[0] === 1'b1) return;
    end
    bad_count++;
    $display("Error done flag expected 1 seen 0");
    stop_test();
  endtask
  // the settle wait covers the standard post-transfer gap
  task automatic run(input logic [15:0] wrap, input logic [15:0] dly);
    regOp(`QSS_SEL_WRAP, 1'b1, wrap);
    regOp(`QSS_SEL_DELAY, 1'b1, 16'h8000 | dly);
    waitDone();
    repeat (20) @(posedge clk);
    regOp(`QSS_SEL_WRAP, 1'b0, 16'h0000);
  endtask
  initial begin
    resetn = 1'b0;
    regReq = '0;
    clock_polarity = 1'b0;
    clock_phase = 1'b0;
    nBits = 5'h08;
    reply = 16'h0000;
    {bad_count, check_count, cyc, fallAt, riseAt, gap, leadDly, csRises} = '0;
    {prevCs, seenCs, prevSck, sckSeen} = 10'h3FC;
    repeat (20) @(posedge clk);
    #2;
    resetn = 1'b1;
    check("idle selects", 16'h000F, {12'h000, spiCsN});
    regOp(`QSS_SEL_WRAP, 1'b0, 16'h0000);
    check("wrap reset", 16'h1000, rd);
    regOp(3'h6, 1'b0, 16'h0000);
    check("unmapped", 16'h0000, rd);
    regOp(`QSS_SEL_IRQ, 1'b1, 16'h0100);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      mask = 16'hFFFF >> (16 - rows[i].n);
      clock_polarity = rows[i].mode[9];
      clock_phase = rows[i].mode[8];
      nBits = 5'(rows[i].n);
      reply = rows[i].rep;
      regOp(`QSS_SEL_MODE, 1'b1, rows[i].mode);
      load(4'(i), rows[i].cmd, rows[i].tx);
      r0 = csRises;
      run({4'h1, 4'(i), 4'h0, 4'(i)}, 16'h0000);
      check("done ptr", {4'h1, 4'(i), 4'(i), 4'(i)}, rd);
      check("one word", 16'h0001, 16'(csRises - r0));
      check("selects", {12'h000, rows[i].cmd[3:0]}, {12'h000, seenCs});
      check("mosi word", rows[i].tx & mask, gotWord);
      check("bit count", 16'(rows[i].n), {11'h000, gotBits});
      regOp(`QSS_SEL_ADDR, 1'b1, 16'h0010 + 16'(i));
      regOp(`QSS_SEL_DATA, 1'b0, 16'h0000);
      check("rx word", rows[i].rep & mask, rd);
      check("irq", 16'h0001, {15'h0000, queueDoneIrq});
      regOp(`QSS_SEL_IRQ, 1'b1, 16'h0100);
      regOp(`QSS_SEL_IRQ, 1'b0, 16'h0000);
      check("flag w0", 16'h0101, rd);
      regOp(`QSS_SEL_IRQ, 1'b1, 16'h0101);
      regOp(`QSS_SEL_IRQ, 1'b0, 16'h0000);
      check("flag w1c", 16'h0100, rd);
      check("irq off", 16'h0000, {15'h0000, queueDoneIrq});
    end
    $display("test rows done");
    regOp(`QSS_SEL_ADDR, 1'b1, 16'h0020);
    regOp(`QSS_SEL_DATA, 1'b0, 16'h0000);
    check("cmd unreadable", 16'h0000, rd);
    regOp(`QSS_SEL_MODE, 1'b1, 16'h0000);
    {clock_polarity, clock_phase, nBits} = 7'h08;
    for (int i = 5; i < 8; i++) load(4'(i), 8'h0E, 16'h0011);
    r0 = csRises;
    run(16'h1705, 16'h0000);
    check("queue words", 16'h0003, 16'(csRises - r0));
    check("queue done ptr", 16'h1775, rd);
    check("std post gap", 16'h0013, 16'(gap));
    check("std lead", 16'h0002, 16'(leadDly));
    regOp(`QSS_SEL_IRQ, 1'b1, 16'h0101);
    load(4'h5, 8'h9E, 16'h0011);
    load(4'h6, 8'h3E, 16'h0022);
    load(4'h7, 8'h1E, 16'h0033);
    r0 = csRises;
    run(16'h1705, 16'h0500);
    check("hold_select_continuous words", 16'h0002, 16'(csRises - r0));
    check("zero count post", 16'h0066, 16'(gap));
    check("count lead", 16'h0005, 16'(leadDly));
    $display("test queue done");
    regOp(`QSS_SEL_IRQ, 1'b1, 16'h0101);
    run(16'h5605, 16'h0500);
    regOp(`QSS_SEL_IRQ, 1'b1, 16'h0101);
    waitDone();
    check("wrap reflag", 16'h0101, rd);
    regOp(`QSS_SEL_DELAY, 1'b1, 16'h0000);
    repeat (300) @(posedge clk);
    check("wrap stopped", 16'h000F, {12'h000, spiCsN});
    $display("test wrap done");
    regOp(`QSS_SEL_DELAY, 1'b1, 16'h8000);
    repeat (30) @(posedge clk);
    #2;
    resetn = 1'b0;
    #2;
    check("reset selects", 16'h000F, {12'h000, spiCsN});
    repeat (2) @(posedge clk);
    #2;
    resetn = 1'b1;
    regOp(`QSS_SEL_WRAP, 1'b0, 16'h0000);
    check("wrap after reset", 16'h1000, rd);
    check("irq after reset", 16'h0000, {15'h0000, queueDoneIrq});
    $display("test midrun reset done");
    stop_test();
  end
endmodule
